// [design/sac_top.sv]
// sequencer control of the simultaneous-sampling converter, APB slave
// assumes the analog core samples on conv_sample and presents conv_data
// for conv_chan by the last cycle of each channel slot
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
module sac_top
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // straps: mode pin seen with weak pull-up and weak pull-down
  input wire logic mode_sense_up,
  input wire logic mode_sense_down,
  input wire logic vss_negative,
  // analog core
  input wire logic [DATA_W-1:0] conv_data,
  output logic conv_sample,
  output logic [IDX_W-1:0] conv_chan,
  output logic conv_pair,
  output logic conv_signed,
  output logic conv_swap,
  output logic busy_n
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [CHAN_N-1:0] cfg_sel;
    logic [CHAN_N-1:0] cfg_pair_input_select;
    logic [CHAN_N-1:0] cfg_bip;
    logic [CHAN_N-1:0] cfg_swap;
    logic pd;
    logic [IDX_W-1:0] rd_ptr;
    logic [CHAN_N-1:0][DATA_W-1:0] ram;
    sac_cv_type cv;
    logic [IDX_W-1:0] cv_chan;
    logic [4:0] cv_cnt;
    logic [CHAN_N-1:0] cv_sel;
    logic [CHAN_N-1:0] cv_pair_input_select;
    logic [CHAN_N-1:0] cv_bip;
    logic [CHAN_N-1:0] cv_swap;
    logic sample;
    logic o_pair;
    logic o_signed;
    logic o_swap;
    logic busy_n;
    logic strap_done;
    logic [2:0] settle_cnt;
    sac_mode_type mode;
    logic vss_neg;
  } sac_state_type;

  sac_state_type st;
  sac_state_type n;

  // ---------------------------------------------------------------
  // decode signals
  // ---------------------------------------------------------------
  logic [2:0] pins_sync;
  logic access;
  logic do_wr;
  logic do_rd;
  logic [31:0] rd_eff;
  logic [31:0] wr_eff;
  logic [7:0] cmd;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] base;
  logic [IDX_W:0] above;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sac_sync2 #(
    .WIDTH(3)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({vss_negative, mode_sense_down, mode_sense_up}),
    .sync_out(pins_sync)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // next set channel after cur, wrapping; cur itself if alone or if none is set
  function automatic logic [IDX_W-1:0] next_wrap(
    input logic [CHAN_N-1:0] v,
    input logic [IDX_W-1:0] cur
  );
    logic [IDX_W-1:0] r;
    logic [IDX_W-1:0] k3;
    r = cur;
    for (int k = CHAN_N; k >= 1; k--) begin
      k3 = cur + IDX_W'(k);
      if (v[k3]) begin
        r = k3;
      end
    end
    return r;
  endfunction

  // lowest set channel above cur, with a found flag on top
  function automatic logic [IDX_W:0] next_above(
    input logic [CHAN_N-1:0] v,
    input logic [IDX_W-1:0] cur
  );
    logic [IDX_W:0] r;
    r = '0;
    for (int j = CHAN_N - 1; j >= 0; j--) begin
      if (v[j] && IDX_W'(j) > cur) begin
        r = {1'b1, IDX_W'(j)};
      end
    end
    return r;
  endfunction

  // effective {sel, pair_input_select, bip, swap} for the held strap setting
  function automatic logic [31:0] eff_cfg(
    input sac_mode_type mode,
    input logic vneg,
    input logic [CHAN_N-1:0] sel,
    input logic [CHAN_N-1:0] pair_input_select,
    input logic [CHAN_N-1:0] signed_range_select,
    input logic [CHAN_N-1:0] swap
  );
    logic [CHAN_N-1:0] b;
    b = vneg ? ALL_CHANNELS : CFG_RESET;
    unique case (mode)
      MODE_LOW: eff_cfg = {ALL_CHANNELS, CFG_RESET, b, CFG_RESET};
      MODE_HIGH: eff_cfg = {EVEN_CHANNELS, EVEN_CHANNELS, b, CFG_RESET};
      default: eff_cfg = {sel, pair_input_select, signed_range_select, swap};
    endcase
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n = st;
    n.sample = 1'b0;
    cmd = pwdata[7:0];
    idx = cmd[CMD_IDX_LSB +: IDX_W];
    base = {idx[IDX_W-1:1], 1'b0};
    above = '0;
    wr_eff = '0;
    rd_eff = eff_cfg(st.mode, st.vss_neg, st.cfg_sel, st.cfg_pair_input_select,
                     st.cfg_bip, st.cfg_swap);

    // strap capture once, after the synchronisers settle
    if (!st.strap_done) begin
      if (st.settle_cnt == STRAP_SETTLE) begin
        n.strap_done = 1'b1;
        n.vss_neg = pins_sync[2];
        if (!pins_sync[0] && !pins_sync[1]) begin
          n.mode = MODE_LOW;
        end else if (pins_sync[0] && pins_sync[1]) begin
          n.mode = MODE_HIGH;
        end else begin
          // open, or an inconsistent sense, counts as open
          n.mode = MODE_OPEN;
        end
      end else begin
        n.settle_cnt = st.settle_cnt + 3'h1;
      end
    end

    // apb: one wait cycle, answer registered
    access = psel && penable;
    if (access && !st.pready) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      unique case (paddr)
        OFS_CMD: n.prdata = '0;
        OFS_RESULT: begin
          if (!st.pd) begin
            n.prdata[DATA_W-1:0] = st.ram[st.rd_ptr];
          end
        end
        OFS_STATUS: begin
          n.prdata[ST_BUSY_BIT] = ~st.busy_n;
          n.prdata[ST_PD_BIT] = st.pd;
          n.prdata[ST_MODE_LSB +: 2] = st.mode;
          n.prdata[ST_VSS_BIT] = st.vss_neg;
          n.prdata[ST_PTR_LSB +: IDX_W] = st.rd_ptr;
          n.prdata[ST_STRAP_BIT] = st.strap_done;
        end
        OFS_CONFIG: n.prdata = rd_eff;
        default: n.pslverr = 1'b1;
      endcase
    end else begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    do_wr = access && st.pready && pwrite && paddr == OFS_CMD;
    do_rd = access && st.pready && !pwrite && paddr == OFS_RESULT;

    // consecutive reads walk the configured channels and wrap
    if (do_rd && !st.pd) begin
      n.rd_ptr = next_wrap(rd_eff[31:24], st.rd_ptr);
    end

    // conversion pacing, one slot per channel
    if (st.cv == CV_RUN) begin
      n.cv_cnt = st.cv_cnt + 5'h1;
      if (st.cv_cnt == SLOT_LAST) begin
        // result taken in the last cycle of the slot
        n.ram[st.cv_chan] = conv_data;
        n.cv_cnt = '0;
        above = next_above(st.cv_sel, st.cv_chan);
        if (above[IDX_W]) begin
          n.cv_chan = above[IDX_W-1:0];
        end else begin
          n.cv = CV_IDLE;
          n.busy_n = 1'b1;
        end
      end
    end

    // command writes
    if (do_wr && st.strap_done) begin
      if (st.mode == MODE_OPEN) begin
        n.pd = cmd[CMD_PD_BIT];
        // configuration loads even while powered down
        if (cmd[CMD_PAIR_BIT]) begin
          n.cfg_sel[base] = 1'b1;
          n.cfg_sel[base + IDX_W'(1)] = 1'b0;
          n.cfg_pair_input_select[base] = 1'b1;
          n.cfg_bip[base] = cmd[CMD_SIGNED_BIT];
          n.cfg_swap[base] = idx[0];
        end else begin
          n.cfg_sel[idx] = 1'b1;
          n.cfg_pair_input_select[idx] = 1'b0;
          n.cfg_bip[idx] = cmd[CMD_SIGNED_BIT];
          n.cfg_swap[idx] = 1'b0;
        end
        if (cmd[CMD_HOLD_BIT]) begin
          n.rd_ptr = idx;
        end
      end
      // strapped mode leaves configuration alone
      // snapshot taken after this write's own update
      wr_eff = eff_cfg(st.mode, st.vss_neg, n.cfg_sel, n.cfg_pair_input_select,
                       n.cfg_bip, n.cfg_swap);
      if ((st.mode != MODE_OPEN || !cmd[CMD_HOLD_BIT]) && !n.pd &&
          st.cv == CV_IDLE && wr_eff[31:24] != CFG_RESET) begin
        n.cv = CV_RUN;
        n.sample = 1'b1;
        n.busy_n = 1'b0;
        n.cv_cnt = '0;
        {n.cv_sel, n.cv_pair_input_select, n.cv_bip, n.cv_swap} = wr_eff;
        n.cv_chan = next_wrap(wr_eff[31:24], {IDX_W{1'b1}});
        // reads restart at the lowest converted channel
        n.rd_ptr = n.cv_chan;
      end
    end

    // attributes of the channel now converting
    n.o_pair = n.cv_pair_input_select[n.cv_chan];
    n.o_signed = n.cv_bip[n.cv_chan];
    n.o_swap = n.cv_swap[n.cv_chan];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.busy_n <= 1'b1;
      st.cv <= CV_IDLE;
      st.mode <= MODE_OPEN;
    end else begin
      st <= n;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign conv_sample = st.sample;
  assign conv_chan = st.cv_chan;
  assign conv_pair = st.o_pair;
  assign conv_signed = st.o_signed;
  assign conv_swap = st.o_swap;
  assign busy_n = st.busy_n;

endmodule

// [design/sac_pkg.sv]
// constants, types and offsets of the converter sequencer control
// assumes one 40 MHz clock and an APB master reaching the registers
package sac_pkg;

  // ---------------------------------------------------------------
  // geometry and timing
  // ---------------------------------------------------------------
  localparam int CHAN_N = 8;
  localparam int IDX_W = 3;
  localparam int DATA_W = 8;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLKS_PER_BIT = 9;
  localparam int PHASES_PER_BIT = 2;
  localparam int SLOT_CYCLES = CLKS_PER_BIT * PHASES_PER_BIT;
  localparam logic [4:0] SLOT_LAST = 5'(SLOT_CYCLES - 1);
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0C;

  // ---------------------------------------------------------------
  // command word fields
  // ---------------------------------------------------------------
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_PD_BIT = 3;
  localparam int CMD_HOLD_BIT = 4;
  localparam int CMD_SIGNED_BIT = 5;
  localparam int CMD_PAIR_BIT = 6;

  // ---------------------------------------------------------------
  // status word fields
  // ---------------------------------------------------------------
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_VSS_BIT = 4;
  localparam int ST_PTR_LSB = 5;
  localparam int ST_STRAP_BIT = 8;

  // ---------------------------------------------------------------
  // reset values and patterns
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] ALL_CHANNELS = 8'hFF;
  localparam logic [7:0] EVEN_CHANNELS = 8'h55;

  typedef enum logic [1:0] {
    MODE_OPEN = 2'b00,
    MODE_LOW = 2'b01,
    MODE_HIGH = 2'b10
  } sac_mode_type;

  typedef enum logic [0:0] {
    CV_IDLE = 1'b0,
    CV_RUN = 1'b1
  } sac_cv_type;

endpackage

// [design/sac_sync2.sv]
// two-flop synchroniser for pin inputs
// assumes asynchronous inputs and an active-high asynchronous reset
module sac_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// [tb/sac_core_model.sv]
// analog core stand-in: returns a result tagged with channel, swap, range
// assumes conv_chan and conv_swap are steady through each slot
module sac_core_model
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // converter side
  input wire logic [IDX_W-1:0] conv_chan,
  input wire logic conv_swap,
  input wire logic conv_signed,
  input wire logic busy_n,
  output logic [DATA_W-1:0] conv_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] noise;

  // outside a conversion the result lines toggle every cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      noise <= 8'h5A;
    else
      noise <= ~noise;
  end
  // result of the channel in its slot
  assign conv_data = busy_n ? noise :
    {3'h5, conv_signed, conv_swap, conv_chan};
endmodule

// [tb/sac_checker_assertions.sv]
// port timing checks of the sequencer control
// assumes binding onto sac_top, one clock, active-high reset
module sac_checker
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic conv_sample,
  input wire logic [IDX_W-1:0] conv_chan,
  input wire logic conv_pair,
  input wire logic busy_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] low_cnt;
  logic [4:0] slot;

  // cycles of busy low and position inside the channel slot
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_cnt <= 8'h00;
      slot <= 5'h00;
    end else if (busy_n) begin
      low_cnt <= 8'h00;
      slot <= 5'h00;
    end else begin
      low_cnt <= low_cnt + 8'h01;
      slot <= (slot == SLOT_LAST) ? 5'h00 : slot + 5'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_slot_run;
    (!conv_sample && !busy_n) [*8];
  endsequence
  property p_sample_busy; conv_sample |-> !busy_n; endproperty
  property p_fall; $fell(busy_n) |-> conv_sample; endproperty
  property p_once; conv_sample |=> s_slot_run; endproperty
  property p_start;
    conv_sample |-> $past(psel && penable && pready && pwrite)
      && $past(paddr) == OFS_CMD;
  endproperty
  property p_len;
    $rose(busy_n) |-> low_cnt % 18 == 0 && low_cnt >= 18 && low_cnt <= 144;
  endproperty
  property p_end; $rose(busy_n) |-> $past(slot) == SLOT_LAST; endproperty
  property p_stable; !busy_n && slot != 5'h00 |-> $stable(conv_chan);
  endproperty
  property p_order;
    !busy_n && slot == 5'h00 && !conv_sample |-> conv_chan > $past(conv_chan);
  endproperty
  property p_pair; conv_pair |-> !conv_chan[0]; endproperty

  a_sample_busy: assert property (p_sample_busy)
    else $error("sample pulse without busy");
  a_fall: assert property (p_fall)
    else $error("busy fell without sample pulse");
  a_once: assert property (p_once)
    else $error("sample pulse repeated or busy short");
  a_start: assert property (p_start)
    else $error("sample pulse without command write");
  a_len: assert property (p_len)
    else $error("busy length not whole slots");
  a_end: assert property (p_end)
    else $error("busy ended inside a slot");
  a_stable: assert property (p_stable)
    else $error("channel changed inside slot");
  a_order: assert property (p_order)
    else $error("channels not in rising order");
  a_pair: assert property (p_pair)
    else $error("pair on odd channel");
endmodule

bind sac_top sac_checker u_sac_checker (.clk_sys(clk_sys), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .conv_sample(conv_sample), .conv_chan(conv_chan),
  .conv_pair(conv_pair), .busy_n(busy_n));

// [tb/tb.sv]
// self-checking bench of the sequencer control over apb
// assumes sac_top, the core model and the bound checker
module tb;
  import sac_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
  logic mode_sense_up, mode_sense_down, vss_negative;
  logic conv_swap, conv_signed, busy_n;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DATA_W-1:0] conv_data;
  logic [IDX_W-1:0] conv_chan;
  int mismatches, n_compared, cycles, m, i;
  // reference kept powered: 50 us wake wait; an internal one needs 5 ms
  localparam int WAKE_CYCLES = 2000;

  sac_top u_sac_top (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_sense_up(mode_sense_up), .mode_sense_down(mode_sense_down),
    .vss_negative(vss_negative), .conv_data(conv_data),
    .conv_sample(), .conv_chan(conv_chan), .conv_pair(),
    .conv_signed(conv_signed), .conv_swap(conv_swap), .busy_n(busy_n));
  sac_core_model u_sac_core_model (.clk_sys(clk_sys), .reset(reset),
    .conv_chan(conv_chan), .conv_swap(conv_swap),
    .conv_signed(conv_signed), .busy_n(busy_n),
    .conv_data(conv_data));

  always #12.5 clk_sys = ~clk_sys;

  task automatic print_verdict;
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer: setup, access, hold until pready
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_cmd(input logic [7:0] d);
    apb(1'b1, OFS_CMD, {24'h000000, d}, rd, err);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    apb(1'b0, a, 32'h00000000, rd, err);
  endtask

  task automatic wait_conv(input int n);
    int c;
    c = 0;
    do @(posedge clk_sys); while (busy_n !== 1'b0);
    while (busy_n === 1'b0) begin
      c++;
      @(posedge clk_sys);
    end
    chk(32'(c), 32'(18 * n));
  endtask

  task automatic do_reset(input logic up, input logic dn, input logic vs);
    mode_sense_up <= up;
    mode_sense_down <= dn;
    vss_negative <= vs;
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    do_reset(1'b1, 1'b0, 1'b0);
    wr_cmd(8'h11);
    wr_cmd(8'h53);
    rd_reg(OFS_CONFIG);
    chk(rd, 32'h06040004);
    wr_cmd(8'h42);
    wait_conv(2);
    rd_reg(OFS_RESULT);
    chk(rd, 32'h000000A1);
    rd_reg(OFS_RESULT);
    chk(rd, 32'h000000A2);
    rd_reg(OFS_RESULT);
    chk(rd, 32'h000000A1);
    wr_cmd(8'h19);
    rd_reg(OFS_STATUS);
    chk(rd & 32'h00000002, 32'h00000002);
    rd_reg(OFS_RESULT);
    chk(rd, 32'h00000000);
    wr_cmd(8'h09);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, busy_n}, 32'h00000001);
    wr_cmd(8'h11);
    rd_reg(OFS_STATUS);
    chk(rd & 32'h00000002, 32'h00000000);
    repeat (WAKE_CYCLES) @(posedge clk_sys);
    wr_cmd(8'h01);
    wait_conv(2);
    rd_reg(OFS_RESULT);
    chk(rd, 32'h000000A1);
    apb(1'b0, 8'h10, 32'h00000000, rd, err);
    chk({31'h0, err}, 32'h00000001);
    for (m = 0; m < 2; m++) begin
      do_reset(m[0], m[0], !m[0]);
      wr_cmd(8'hFF);
      wait_conv(8 - 4 * m);
      rd_reg(OFS_CONFIG);
      chk(rd, m ? 32'h55550000 : 32'hFF00FF00);
      for (i = 0; i < 8 - 4 * m; i++) begin
        rd_reg(OFS_RESULT);
        chk(rd, {24'h0, (m ? 5'h14 : 5'h16),
          3'(m ? 2 * i : i)});
      end
    end
    print_verdict;
  end
endmodule
